// ---- hw/pamx_defines.vh ----
// Constants for the port alternate function mux
`ifndef PAMX_DEFINES_VH
`define PAMX_DEFINES_VH

// Bit positions of the input switch control register
`define PAMX_ISC_IRQ0        0
`define PAMX_ISC_CAPTURE     1
`define PAMX_ISC_T52GATE     2
`define PAMX_ISC_RXPIN       3
`define PAMX_ISC_BIT4        4
`define PAMX_ISC_BIT5        5

// Widths
`define PAMX_P10_W           4
`define PAMX_P11_W           4
`define PAMX_P2_W            8

// Reset values
`define PAMX_RST_SEL         1'b0
`define PAMX_RST_PORT4       4'h0
`define PAMX_RST_PORT8       8'h00
`define PAMX_RST_OSC         8'h00
`define PAMX_RST_ISC         8'h00
`define PAMX_RST_DIR4        4'hf
`define PAMX_RST_OE4         4'hf
`define PAMX_RST_OE8         8'hff

// Oscillator mode select: bits that claim the sub and, with debug disabled, the main oscillator pin pairs
`define PAMX_OSC_MAIN_LO     6
`define PAMX_OSC_MAIN_HI     7
`define PAMX_OSC_SUB         5

// Serial receive is port 11 bit 3, transmit bit 2
`define PAMX_RX_BIT          3
`define PAMX_TX_BIT          2

`endif

// ---- hw/pamx_port_mux.v ----
// Port alternate function pin multiplexer
`timescale 1ns/1ps
`include "pamx_defines.vh"

module pamx_port_mux
(
  input  wire       sys_clk_in,
  input  wire       rst_n_in,
  // Software writes, one bit at a time
  input  wire       cfg_wr_in,
  input  wire [2:0] cfg_sel_in,
  input  wire [2:0] cfg_bit_in,
  input  wire       cfg_val_in,
  // Whole-register views and controls
  input  wire [7:0] input_switch_control_in,
  input  wire       input_switch_wr_in,
  input  wire [7:0] osc_mode_select_in,
  input  wire       osc_mode_wr_in,
  input  wire       debug_enable_in,
  input  wire       quarter_bias_in,
  input  wire       port_function_bit13_in,
  input  wire [7:0] port_function_reg2_in,
  input  wire [7:0] analog_port_config_in,
  input  wire [7:0] direction_reg_port2_in,
  input  wire [7:0] analog_channel_select_in,
  // Port latches from the port logic
  input  wire [3:0] latch_port10_in,
  input  wire [3:0] latch_port11_in,
  input  wire [7:0] latch_port2_in,
  input  wire       latch_port4_bit0_in,
  input  wire [3:0] latch_port12_osc_in,
  // Far-side peripheral signals
  input  wire [3:0] lcd_segment_port10_in,
  input  wire [3:0] lcd_segment_port11_in,
  input  wire [7:0] lcd_segment_port2_in,
  input  wire       uart_b_transmit_in,
  input  wire       timer_h_unit_2_in,
  input  wire       timer8_unit_c_enable_in,
  // Pin inputs
  input  wire [3:0] pin_port10_in,
  input  wire [3:0] pin_port11_in,
  input  wire [7:0] pin_port2_in,
  input  wire       pin_port4_bit0_in,
  input  wire       pin_irq0_in,
  input  wire       pin_timer16_capture_in,
  input  wire [3:0] pin_port12_osc_in,
  // Pin drive: value, output enable active low, pull-up enable
  output reg  [3:0] pin_port10_out,
  output reg  [3:0] pin_port10_oe_n_out,
  output reg  [3:0] pullup_port10_out,
  output reg  [3:0] pin_port11_out,
  output reg  [3:0] pin_port11_oe_n_out,
  output reg  [3:0] pullup_port11_out,
  output reg  [7:0] pin_port2_out,
  output reg  [7:0] pin_port2_oe_n_out,
  output reg  [7:0] analog_enable_out,
  output reg  [7:0] analog_convert_out,
  output reg        pin_port4_bit0_out,
  output reg        pin_port4_bit0_oe_n_out,
  output reg        lcd_bias_voltage3_out,
  output reg  [3:0] pin_port12_osc_out,
  output reg  [3:0] pin_port12_osc_oe_n_out,
  output reg  [1:0] debug_pin_select_out,
  output reg  [1:0] osc_pin_select_out,
  // Routed signals toward peripherals
  output reg        uart_b_receive_out,
  output reg        timer16_capture_input_out,
  output reg        ext_irq_input_0_out,
  output reg        key_return_input0_out,
  output reg        timer8_unit_c_count_en_out,
  output reg  [3:0] port10_read_out,
  output reg  [3:0] port11_read_out,
  // Register read-back
  output reg        segment_port_select_out,
  output reg  [3:0] direction_reg_port10_out,
  output reg  [3:0] pullup_reg_port10_out,
  output reg  [3:0] direction_reg_port11_out,
  output reg  [3:0] pullup_reg_port11_out,
  output reg  [7:0] input_switch_control_out,
  output reg  [7:0] osc_mode_select_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  localparam [2:0] SEL_SEGMENT = 3'h0;
  localparam [2:0] SEL_DIR10   = 3'h1;
  localparam [2:0] SEL_PULLUP_REG_PORT10    = 3'h2;
  localparam [2:0] SEL_DIR11   = 3'h3;
  localparam [2:0] SEL_PULLUP_REG_PORT11    = 3'h4;

  reg  [3:0] next_dir10;
  reg  [3:0] next_pullup_reg_port10;
  reg  [3:0] next_dir11;
  reg  [3:0] next_pullup_reg_port11;
  reg        next_seg;
  wire [1:0] bidx;

  assign bidx = cfg_bit_in[1:0];

  always @*
  begin
    next_seg   = segment_port_select_out;
    next_dir10 = direction_reg_port10_out;
    next_pullup_reg_port10  = pullup_reg_port10_out;
    next_dir11 = direction_reg_port11_out;
    next_pullup_reg_port11  = pullup_reg_port11_out;
    if (cfg_wr_in)
    begin
      case (cfg_sel_in)
        SEL_SEGMENT: next_seg = cfg_val_in;
        SEL_DIR10:   next_dir10[bidx] = cfg_val_in;
        SEL_PULLUP_REG_PORT10:    next_pullup_reg_port10[bidx]  = cfg_val_in;
        SEL_DIR11:   next_dir11[bidx] = cfg_val_in;
        SEL_PULLUP_REG_PORT11:    next_pullup_reg_port11[bidx]  = cfg_val_in;
        default:     next_seg = segment_port_select_out;
      endcase
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      segment_port_select_out  <= `PAMX_RST_SEL;
      direction_reg_port10_out <= `PAMX_RST_DIR4;
      pullup_reg_port10_out    <= `PAMX_RST_PORT4;
      direction_reg_port11_out <= `PAMX_RST_DIR4;
      pullup_reg_port11_out    <= `PAMX_RST_PORT4;
      input_switch_control_out <= `PAMX_RST_ISC;
      osc_mode_select_out      <= `PAMX_RST_OSC;
    end
    else
    begin
      segment_port_select_out  <= next_seg;
      direction_reg_port10_out <= next_dir10;
      pullup_reg_port10_out    <= next_pullup_reg_port10;
      direction_reg_port11_out <= next_dir11;
      pullup_reg_port11_out    <= next_pullup_reg_port11;
      if (input_switch_wr_in)
        input_switch_control_out <= input_switch_control_in;
      if (osc_mode_wr_in)
        osc_mode_select_out <= osc_mode_select_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port 10 and port 11 pins
  wire       seg;
  wire [7:0] input_switch_control;
  wire       rx_ok;

  assign seg = segment_port_select_out;
  assign input_switch_control = input_switch_control_out;
  assign rx_ok = !seg && input_switch_control[`PAMX_ISC_RXPIN] && !input_switch_control[`PAMX_ISC_BIT4] &&
                 !input_switch_control[`PAMX_ISC_BIT5] && direction_reg_port11_out[`PAMX_RX_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_p1x
      always @(posedge sys_clk_in)
      begin
        if (!rst_n_in)
        begin
          pin_port10_out[gi]      <= 1'b0;
          pin_port10_oe_n_out[gi] <= 1'b1;
          pullup_port10_out[gi]   <= 1'b0;
          pin_port11_out[gi]      <= 1'b0;
          pin_port11_oe_n_out[gi] <= 1'b1;
          pullup_port11_out[gi]   <= 1'b0;
          port10_read_out[gi]     <= 1'b0;
          port11_read_out[gi]     <= 1'b0;
        end
        else
        begin
          if (seg)
          begin
            pin_port10_out[gi]      <= lcd_segment_port10_in[gi];
            pin_port10_oe_n_out[gi] <= 1'b0;
            pullup_port10_out[gi]   <= 1'b0;
            pin_port11_out[gi]      <= lcd_segment_port11_in[gi];
            pin_port11_oe_n_out[gi] <= 1'b0;
            pullup_port11_out[gi]   <= 1'b0;
          end
          else
          begin
            pin_port10_out[gi]      <= latch_port10_in[gi];
            pin_port10_oe_n_out[gi] <= direction_reg_port10_out[gi];
            pullup_port10_out[gi]   <= pullup_reg_port10_out[gi] & direction_reg_port10_out[gi];
            if (gi == `PAMX_TX_BIT)
              pin_port11_out[gi]    <= latch_port11_in[gi] & uart_b_transmit_in;
            else
              pin_port11_out[gi]    <= latch_port11_in[gi];
            pin_port11_oe_n_out[gi] <= direction_reg_port11_out[gi];
            pullup_port11_out[gi]   <= pullup_reg_port11_out[gi] & direction_reg_port11_out[gi];
          end
          port10_read_out[gi] <= seg ? 1'b0 : pin_port10_in[gi];
          port11_read_out[gi] <= seg ? 1'b0 : pin_port11_in[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Input switch routing
  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      uart_b_receive_out         <= 1'b1;
      timer16_capture_input_out  <= 1'b0;
      ext_irq_input_0_out        <= 1'b0;
      timer8_unit_c_count_en_out <= 1'b0;
    end
    else
    begin
      uart_b_receive_out <= rx_ok ? pin_port11_in[`PAMX_RX_BIT] : 1'b1;
      timer16_capture_input_out <= input_switch_control[`PAMX_ISC_CAPTURE] ?
                                   uart_b_receive_out : pin_timer16_capture_in;
      ext_irq_input_0_out <= input_switch_control[`PAMX_ISC_IRQ0] ? uart_b_receive_out : pin_irq0_in;
      timer8_unit_c_count_en_out <= input_switch_control[`PAMX_ISC_T52GATE] ?
                                    (timer8_unit_c_enable_in & timer_h_unit_2_in) :
                                    timer8_unit_c_enable_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port 4 bit 0, port 2 and oscillator pins
  wire main_osc;
  wire sub_osc;
  wire p13_free;

  assign main_osc = osc_mode_select_out[`PAMX_OSC_MAIN_HI] | osc_mode_select_out[`PAMX_OSC_MAIN_LO];
  assign sub_osc  = osc_mode_select_out[`PAMX_OSC_SUB];
  assign p13_free = !port_function_bit13_in;

  integer k;
  always @(posedge sys_clk_in)
  begin
    if (!rst_n_in)
    begin
      pin_port4_bit0_out      <= 1'b0;
      pin_port4_bit0_oe_n_out <= 1'b1;
      lcd_bias_voltage3_out   <= 1'b0;
      key_return_input0_out   <= 1'b1;
      pin_port2_out           <= `PAMX_RST_PORT8;
      pin_port2_oe_n_out      <= `PAMX_RST_OE8;
      analog_enable_out       <= `PAMX_RST_PORT8;
      analog_convert_out      <= `PAMX_RST_PORT8;
      pin_port12_osc_out      <= `PAMX_RST_PORT4;
      pin_port12_osc_oe_n_out <= `PAMX_RST_OE4;
      debug_pin_select_out    <= 2'h0;
      osc_pin_select_out      <= 2'h0;
    end
    else
    begin
      lcd_bias_voltage3_out   <= quarter_bias_in;
      pin_port4_bit0_out      <= latch_port4_bit0_in;
      pin_port4_bit0_oe_n_out <= quarter_bias_in | !p13_free;
      key_return_input0_out   <= quarter_bias_in ? 1'b1 : pin_port4_bit0_in;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (port_function_reg2_in[k])
        begin
          pin_port2_out[k]      <= lcd_segment_port2_in[k];
          pin_port2_oe_n_out[k] <= 1'b0;
          analog_enable_out[k]  <= 1'b0;
          analog_convert_out[k] <= 1'b0;
        end
        else
        begin
          pin_port2_out[k]      <= latch_port2_in[k];
          pin_port2_oe_n_out[k] <= direction_reg_port2_in[k] | analog_port_config_in[k];
          analog_enable_out[k]  <= analog_port_config_in[k] & direction_reg_port2_in[k];
          analog_convert_out[k] <= analog_port_config_in[k] & direction_reg_port2_in[k] &
                                   (analog_channel_select_in[2:0] == k[2:0]);
        end
      end
      debug_pin_select_out <= {2{debug_enable_in}};
      osc_pin_select_out   <= {sub_osc, main_osc & !debug_enable_in};
      pin_port12_osc_out   <= latch_port12_osc_in;
      pin_port12_osc_oe_n_out[1:0] <= 2'h3;
      pin_port12_osc_oe_n_out[3:2] <= 2'h3;
    end
  end

endmodule

// ---- sim/pamx_port_mux_asserts.sv ----
// Assertion checker for the port mux
`timescale 1ns/1ps
module pamx_chk
(
  input logic       sys_clk_in,
  input logic       rst_n_in,
  input logic       cfg_wr_in,
  input logic [2:0] cfg_sel_in,
  input logic [2:0] cfg_bit_in,
  input logic       cfg_val_in,
  input logic [3:0] pin_port11_in,
  input logic       pin_irq0_in,
  input logic       pin_timer16_capture_in,
  input logic       timer_h_unit_2_in,
  input logic       timer8_unit_c_enable_in,
  input logic [3:0] lcd_segment_port10_in,
  input logic       segment_port_select_out,
  input logic [3:0] direction_reg_port10_out,
  input logic [3:0] direction_reg_port11_out,
  input logic [7:0] input_switch_control_out,
  input logic [3:0] pin_port10_oe_n_out,
  input logic [3:0] pin_port10_out,
  input logic       uart_b_receive_out,
  input logic       timer16_capture_input_out,
  input logic       ext_irq_input_0_out,
  input logic       timer8_unit_c_count_en_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////
  sequence s_rx_on;
    !segment_port_select_out && input_switch_control_out[5:3] == 3'h1 && direction_reg_port11_out[3];
  endsequence
  sequence s_dir_wr;
    cfg_wr_in && cfg_sel_in == 3'h1;
  endsequence
  a_dir_write:
    assert property (s_dir_wr |=> direction_reg_port10_out[$past(cfg_bit_in[1:0])] == $past(cfg_val_in))
    else $error("direction write lost");
  a_port_dir:
    assert property (!segment_port_select_out |=> pin_port10_oe_n_out == $past(direction_reg_port10_out))
    else $error("port drive differs from direction");
  a_seg_drive:
    assert property (segment_port_select_out |=> pin_port10_oe_n_out == 4'h0 &&
      pin_port10_out == $past(lcd_segment_port10_in))
    else $error("segment drive wrong");
  a_rx_route:
    assert property (s_rx_on |=> uart_b_receive_out == $past(pin_port11_in[3]))
    else $error("serial receive not routed");
  a_rx_idle:
    assert property (!input_switch_control_out[3] |=> uart_b_receive_out)
    else $error("serial receive not idle");
  a_cap_route:
    assert property (1'b1 |=> timer16_capture_input_out == ($past(input_switch_control_out[1]) ?
      $past(uart_b_receive_out) : $past(pin_timer16_capture_in)))
    else $error("capture source wrong");
  a_irq_route:
    assert property (1'b1 |=> ext_irq_input_0_out == ($past(input_switch_control_out[0]) ?
      $past(uart_b_receive_out) : $past(pin_irq0_in)))
    else $error("interrupt source wrong");
  a_t52_gate:
    assert property (1'b1 |=> timer8_unit_c_count_en_out == ($past(input_switch_control_out[2]) ?
      $past(timer8_unit_c_enable_in) && $past(timer_h_unit_2_in) : $past(timer8_unit_c_enable_in)))
    else $error("count enable gate wrong");
endmodule
bind pamx_port_mux pamx_chk u_chk (.*);

// ---- sim/pamx_far_model.sv ----
// Far-side model: segment driver, serial transmit, timer H2
`timescale 1ns/1ps
module pamx_far_model
(
  input  wire       sys_clk_in,
  input  wire       tx_in,
  input  wire       h2_in,
  output reg  [3:0] seg10_out,
  output reg  [3:0] seg11_out,
  output reg  [7:0] seg2_out,
  output reg        tx_out,
  output reg        h2_out
);
  always @(posedge sys_clk_in)
  begin
    seg10_out <= 4'h5;
    seg11_out <= 4'h9;
    seg2_out  <= 8'h3c;
    tx_out    <= tx_in;
    h2_out    <= h2_in;
  end
endmodule

// ---- sim/tb_pamx_port_mux.sv ----
// Testbench for the port mux
`timescale 1ns/1ps
module tb_pamx_port_mux;
  logic       sys_clk_in = 0, rst_n_in = 0, cfg_wr_in = 0, cfg_val_in = 0, input_switch_wr_in = 0, tx_lvl = 0;
  logic       osc_mode_wr_in = 0, debug_enable_in = 0, quarter_bias_in = 0, port_function_bit13_in = 0, h2_lvl = 0;
  logic       latch_port4_bit0_in = 0, timer8_unit_c_enable_in = 0, pin_port4_bit0_in = 0, pin_irq0_in = 0;
  logic       pin_timer16_capture_in = 0, uart_b_transmit_in, timer_h_unit_2_in;
  logic [2:0] cfg_sel_in = 0, cfg_bit_in = 0;
  logic [7:0] input_switch_control_in = 0, osc_mode_select_in = 0, port_function_reg2_in = 0, pin_port2_in = 0;
  logic [7:0] analog_port_config_in = 0, direction_reg_port2_in = 0, analog_channel_select_in = 0, latch_port2_in = 0;
  logic [3:0] latch_port10_in = 0, latch_port11_in = 0, latch_port12_osc_in = 0, pin_port10_in = 0;
  logic [3:0] pin_port11_in = 0, pin_port12_osc_in = 0, lcd_segment_port10_in, lcd_segment_port11_in;
  logic [7:0] lcd_segment_port2_in, pin_port2_out, pin_port2_oe_n_out, analog_enable_out, analog_convert_out;
  logic [7:0] input_switch_control_out, osc_mode_select_out;
  logic [3:0] pin_port10_out, pin_port10_oe_n_out, pullup_port10_out, pin_port11_out, pin_port11_oe_n_out;
  logic [3:0] pullup_port11_out, pin_port12_osc_out, pin_port12_osc_oe_n_out, port10_read_out, port11_read_out;
  logic [3:0] direction_reg_port10_out, pullup_reg_port10_out, direction_reg_port11_out, pullup_reg_port11_out;
  logic [1:0] debug_pin_select_out, osc_pin_select_out;
  logic       pin_port4_bit0_out, pin_port4_bit0_oe_n_out, lcd_bias_voltage3_out, uart_b_receive_out;
  logic       timer16_capture_input_out, ext_irq_input_0_out, key_return_input0_out, timer8_unit_c_count_en_out;
  logic       segment_port_select_out;
  logic [7:0] blk [3] = '{8'h1b, 8'h2b, 8'h03};
  int         miscompares = 0, checked = 0;
  ////////////////////////////////////////////////////////////////
  always #5 sys_clk_in = ~sys_clk_in;
  pamx_port_mux DUT (.*);
  pamx_far_model far (.sys_clk_in, .tx_in(tx_lvl), .h2_in(h2_lvl), .seg10_out(lcd_segment_port10_in),
    .seg11_out(lcd_segment_port11_in), .seg2_out(lcd_segment_port2_in), .tx_out(uart_b_transmit_in),
    .h2_out(timer_h_unit_2_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] sel, input logic [2:0] b, input logic v);
    cfg_sel_in = sel;
    cfg_bit_in = b;
    cfg_val_in = v;
    cfg_wr_in = 1;
    @(negedge sys_clk_in);
  endtask
  task automatic sw(input logic [7:0] v);
    input_switch_control_in = v;
    input_switch_wr_in = 1;
    @(negedge sys_clk_in);
  endtask
  task automatic settle(input int n);
    cfg_wr_in = 0;
    input_switch_wr_in = 0;
    osc_mode_wr_in = 0;
    repeat (n) @(negedge sys_clk_in);
  endtask
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge sys_clk_in);
    rst_n_in = 1;
    chk("dir10", direction_reg_port10_out, 8'h0f);
    chk("pullup_reg_port10", pullup_reg_port10_out, 8'h00);
    chk("isc", input_switch_control_out, 8'h00);
    chk("osc", osc_mode_select_out, 8'h00);
    chk("rx", uart_b_receive_out, 8'h01);
    $display("reset test done");
    latch_port10_in = 4'ha;
    pin_port10_in = 4'hc;
    wr(3'h1, 3'h0, 1'b0);
    wr(3'h1, 3'h3, 1'b0);
    wr(3'h2, 3'h1, 1'b1);
    wr(3'h5, 3'h2, 1'b0);
    settle(3);
    chk("dir10", direction_reg_port10_out, 8'h06);
    chk("oe10", pin_port10_oe_n_out, 8'h06);
    chk("pull10", pullup_port10_out, 8'h02);
    chk("out10", pin_port10_out & ~pin_port10_oe_n_out, 8'h08);
    chk("rd10", port10_read_out, 8'h0c);
    wr(3'h0, 3'h0, 1'b1);
    settle(3);
    chk("seg oe10", pin_port10_oe_n_out, 8'h00);
    chk("seg sel", segment_port_select_out, 8'h01);
    chk("seg rd10", port10_read_out, 8'h00);
    chk("seg out10", pin_port10_out, 8'h05);
    chk("seg pull10", pullup_port10_out, 8'h00);
    chk("seg dir10", direction_reg_port10_out, 8'h06);
    chk("seg oe11", pin_port11_oe_n_out, 8'h00);
    chk("seg out11", pin_port11_out, 8'h09);
    wr(3'h0, 3'h0, 1'b0);
    settle(3);
    chk("oe10 back", pin_port10_oe_n_out, 8'h06);
    $display("port10 test done");
    latch_port11_in = 4'hf;
    wr(3'h3, 3'h2, 1'b0);
    wr(3'h4, 3'h0, 1'b1);
    settle(3);
    chk("oe11", pin_port11_oe_n_out, 8'h0b);
    chk("pull11", pullup_port11_out, 8'h01);
    chk("dir11", direction_reg_port11_out, 8'h0b);
    chk("pullup_reg_port11", pullup_reg_port11_out, 8'h01);
    chk("tx low", pin_port11_out[2], 8'h00);
    tx_lvl = 1;
    settle(3);
    chk("tx high", pin_port11_out[2], 8'h01);
    $display("port11 test done");
    pin_irq0_in = 1;
    pin_timer16_capture_in = 1;
    sw(8'h08);
    settle(3);
    chk("rx on", uart_b_receive_out, 8'h00);
    chk("irq pin", ext_irq_input_0_out, 8'h01);
    chk("cap pin", timer16_capture_input_out, 8'h01);
    sw(8'h0b);
    settle(3);
    chk("cap rx", timer16_capture_input_out, 8'h00);
    chk("irq rx", ext_irq_input_0_out, 8'h00);
    foreach (blk[i])
    begin
      sw(blk[i]);
      settle(3);
      chk("rx blocked", uart_b_receive_out, 8'h01);
    end
    sw(8'h08);
    wr(3'h3, 3'h3, 1'b0);
    settle(3);
    chk("rx dir out", uart_b_receive_out, 8'h01);
    $display("routing test done");
    timer8_unit_c_enable_in = 1;
    sw(8'h04);
    settle(3);
    chk("t52 gated", timer8_unit_c_count_en_out, 8'h00);
    h2_lvl = 1;
    settle(3);
    chk("t52 open", timer8_unit_c_count_en_out, 8'h01);
    h2_lvl = 0;
    sw(8'h00);
    settle(3);
    chk("t52 free", timer8_unit_c_count_en_out, 8'h01);
    port_function_bit13_in = 0;
    settle(3);
    chk("key", key_return_input0_out, 8'h00);
    chk("p40 oe", pin_port4_bit0_oe_n_out, 8'h00);
    chk("bias off", lcd_bias_voltage3_out, 8'h00);
    quarter_bias_in = 1;
    osc_mode_select_in = 8'hc0;
    osc_mode_wr_in = 1;
    @(negedge sys_clk_in);
    settle(3);
    chk("bias on", lcd_bias_voltage3_out, 8'h01);
    chk("p40 bias oe", pin_port4_bit0_oe_n_out, 8'h01);
    chk("key bias", key_return_input0_out, 8'h01);
    chk("osc", osc_mode_select_out, 8'hc0);
    chk("osc pins", osc_pin_select_out, 8'h01);
    chk("osc oe", pin_port12_osc_oe_n_out, 8'h0f);
    debug_enable_in = 1;
    settle(3);
    chk("debug pins", debug_pin_select_out, 8'h03);
    chk("osc pins dbg", osc_pin_select_out, 8'h00);
    $display("misc test done");
    port_function_reg2_in = 8'h01;
    analog_port_config_in = 8'h06;
    direction_reg_port2_in = 8'h04;
    analog_channel_select_in = 8'h02;
    latch_port2_in = 8'ha5;
    settle(3);
    chk("p2 oe", pin_port2_oe_n_out, 8'h06);
    chk("p2 out", pin_port2_out, 8'ha4);
    chk("p2 analog", analog_enable_out, 8'h04);
    chk("p2 convert", analog_convert_out, 8'h04);
    $display("port2 test done");
    summarize();
  end
endmodule
